// File: hw/timer_pulse_pkg.sv
// Purpose: Shared constants for the timer pulse generator
// Assumes: 32-bit Avalon-MM register word, 200 MHz reference clock
// Notes: Offsets are byte addresses of aligned words
package timer_pulse_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] CYCLE_OFS = 4'h4;
   localparam logic [3:0] WIDTH_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hC;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int CLKSEL_LSB = 2;
   localparam int START_LSB = 4;
   localparam int REPEAT_BIT = 6;
   localparam int FFCTL_BIT = 7;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_PULSE = 2'h3;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_CMD = 2'h1;
   localparam logic [1:0] START_RISE = 2'h2;
   localparam logic [1:0] START_FALL = 2'h3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int STAT_COUNT_LSB = 0;
   localparam int STAT_RUN_BIT = 16;
   localparam int STAT_FF_BIT = 17;
   localparam int STAT_PHASE_BIT = 18;
   // ----------------------------------------------------------------
   // Source clock dividers, as log2 of the division ratio
   // ----------------------------------------------------------------
   localparam logic [3:0] DIV_LOG_SEL0 = 4'h7;
   localparam logic [3:0] DIV_LOG_SEL1 = 4'h5;
   localparam logic [3:0] DIV_LOG_SEL2 = 4'h3;
   localparam logic [3:0] DIV_LOG_SEL3 = 4'h0;
endpackage : timer_pulse_pkg

// File: hw/timer_evt_if.sv
// Purpose: Carries source tick and trigger edges to the timer core
// Assumes: Single clock domain
// Notes: One modport per producer, one for the consumer
interface timer_evt_if;
   logic [1:0] clk_sel;
   logic tick;
   logic rise;
   logic fall;
   modport prescaler (input clk_sel, output tick);
   modport edges (output rise, output fall);
   modport core (output clk_sel, input tick, input rise, input fall);
endinterface : timer_evt_if

// File: hw/timer_prescaler.sv
// Purpose: Divides the reference clock into the counter source tick
// Assumes: Select comes from the control register
// Notes: Tick is a one-cycle pulse for selects 0 to 2, held high for select 3
module timer_prescaler #(
   parameter int DIV_W = 8
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   timer_evt_if.prescaler evt
);
   logic [DIV_W-1:0] div_reg;

   function automatic logic [DIV_W-1:0] div_mask(input logic [1:0] sel);
      logic [3:0] lg;
      lg = timer_pulse_pkg::DIV_LOG_SEL3;
      unique case (sel)
         2'h0: lg = timer_pulse_pkg::DIV_LOG_SEL0;
         2'h1: lg = timer_pulse_pkg::DIV_LOG_SEL1;
         2'h2: lg = timer_pulse_pkg::DIV_LOG_SEL2;
         2'h3: lg = timer_pulse_pkg::DIV_LOG_SEL3;
      endcase
      return DIV_W'((1 << lg) - 1);
   endfunction : div_mask

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   assign evt.tick = ((div_reg & div_mask(evt.clk_sel)) ==
                      div_mask(evt.clk_sel));
endmodule : timer_prescaler

// File: hw/timer_edge_sync.sv
// Purpose: Synchronises the trigger pin and detects its edges
// Assumes: Pin is asynchronous to the reference clock
// Notes: Edges are one-cycle pulses after two sync stages
module timer_edge_sync (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   timer_evt_if.edges evt
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign evt.rise = sync_reg & ~last_reg;
   assign evt.fall = ~sync_reg & last_reg;
endmodule : timer_edge_sync

// File: hw/timer_pulse_generator.sv
// Purpose: 16-bit timer in programmable pulse generation mode
// Assumes: Avalon-MM slave with waitrequest, 200 MHz ref_clk_in
// Notes: Pulse pin carries the inverse of the timer flip-flop
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
module timer_pulse_generator #(
   parameter int CNT_W = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic timer_input_pin_in,
   output logic pulse_output_pin_out,
   output logic timer_interrupt_out
);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [7:0] timer_control_reg;
   logic [CNT_W-1:0] cycle_compare_reg;
   logic [CNT_W-1:0] width_compare_reg;
   logic [CNT_W-1:0] count_reg;
   logic running_reg;
   logic timer_flipflop_reg;
   logic phase_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic pin_reg;
   logic irq_reg;

   logic req;
   logic wr_en;
   logic [7:0] wctl;
   logic [1:0] start_field;
   logic pulse_mode;
   logic repeat_select_bit;
   logic advance;
   logic hit_width;
   logic hit_cycle;
   logic toggle;
   logic trig_edge;
   logic ctl_wr;
   logic ff_next;

   timer_evt_if evt ();

   timer_prescaler #(.DIV_W(8)) u_prescaler (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .evt(evt.prescaler)
   );

   timer_edge_sync u_edge_sync (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(timer_input_pin_in),
      .evt(evt.edges)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign start_field = timer_control_reg[timer_pulse_pkg::START_LSB +: 2];
   assign pulse_mode = (timer_control_reg[timer_pulse_pkg::MODE_LSB +: 2]
                        == timer_pulse_pkg::MODE_PULSE);
   assign repeat_select_bit = timer_control_reg[timer_pulse_pkg::REPEAT_BIT];
   assign evt.clk_sel = timer_control_reg[timer_pulse_pkg::CLKSEL_LSB +: 2];

   assign req = avs_read_in | avs_write_in;
   assign wr_en = avs_write_in & ~wait_reg;
   assign ctl_wr = wr_en & avs_byteenable_in[0] &
                   (avs_address_in == timer_pulse_pkg::CTRL_OFS);
   assign wctl = avs_writedata_in[7:0];

   assign advance = running_reg & pulse_mode & evt.tick;
   assign hit_width = advance & (count_reg == width_compare_reg);
   assign hit_cycle = advance & (count_reg == cycle_compare_reg);
   assign toggle = hit_width | hit_cycle;

   assign trig_edge = (start_field == timer_pulse_pkg::START_RISE) ?
                      evt.rise : evt.fall;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= ~(req & wait_reg);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= 32'h00000000;
      end else if (avs_read_in & wait_reg) begin
         unique case (avs_address_in)
            timer_pulse_pkg::CTRL_OFS: begin
               rdata_reg <= {24'h000000, timer_control_reg};
            end
            timer_pulse_pkg::CYCLE_OFS: begin
               rdata_reg <= {16'h0000, cycle_compare_reg};
            end
            timer_pulse_pkg::WIDTH_OFS: begin
               rdata_reg <= {16'h0000, width_compare_reg};
            end
            timer_pulse_pkg::STATUS_OFS: begin
               rdata_reg <= {13'h0000, phase_reg, timer_flipflop_reg,
                             running_reg, count_reg};
            end
            default: begin
               rdata_reg <= 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cycle_compare_reg <= timer_pulse_pkg::COMPARE_RESET;
         width_compare_reg <= timer_pulse_pkg::COMPARE_RESET;
      end else if (wr_en) begin
         if (avs_address_in == timer_pulse_pkg::CYCLE_OFS) begin
            if (avs_byteenable_in[0]) cycle_compare_reg[7:0] <=
               avs_writedata_in[7:0];
            if (avs_byteenable_in[1]) cycle_compare_reg[15:8] <=
               avs_writedata_in[15:8];
         end
         if (avs_address_in == timer_pulse_pkg::WIDTH_OFS) begin
            if (avs_byteenable_in[0]) width_compare_reg[7:0] <=
               avs_writedata_in[7:0];
            if (avs_byteenable_in[1]) width_compare_reg[15:8] <=
               avs_writedata_in[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and run state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_control_reg <= timer_pulse_pkg::CTRL_RESET;
      end else if (ctl_wr) begin
         timer_control_reg <= wctl;
      end else if (hit_cycle & repeat_select_bit) begin
         timer_control_reg[timer_pulse_pkg::START_LSB +: 2] <=
            timer_pulse_pkg::START_STOP;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         running_reg <= 1'b0;
      end else if (ctl_wr) begin
         running_reg <= (wctl[timer_pulse_pkg::START_LSB +: 2] ==
                         timer_pulse_pkg::START_CMD);
      end else if (hit_cycle & repeat_select_bit) begin
         running_reg <= 1'b0;
      end else if (!running_reg & start_field[1] & trig_edge) begin
         running_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Up-counter
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
      end else if (ctl_wr & (wctl[timer_pulse_pkg::START_LSB +: 2] ==
                             timer_pulse_pkg::START_STOP)) begin
         count_reg <= '0;
      end else if (hit_cycle) begin
         count_reg <= '0;
      end else if (advance) begin
         count_reg <= count_reg + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Timer flip-flop and pin
   // ----------------------------------------------------------------
   always_comb begin
      ff_next = timer_flipflop_reg;
      if (toggle) begin
         ff_next = ~timer_flipflop_reg;
      end else if (ctl_wr & ~running_reg &
                   (wctl[timer_pulse_pkg::MODE_LSB +: 2] ==
                    timer_pulse_pkg::MODE_PULSE)) begin
         ff_next = wctl[timer_pulse_pkg::FFCTL_BIT] ^ phase_reg;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_flipflop_reg <= 1'b0;
         pin_reg <= 1'b1;
      end else begin
         timer_flipflop_reg <= ff_next;
         pin_reg <= ~ff_next;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_reg <= 1'b0;
      end else if (toggle) begin
         phase_reg <= ~phase_reg;
      end else if (ctl_wr & (wctl[timer_pulse_pkg::MODE_LSB +: 2] !=
                             timer_pulse_pkg::MODE_PULSE)) begin
         phase_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= toggle;
      end
   end

   assign avs_readdata_out = rdata_reg;
   assign avs_waitrequest_out = wait_reg;
   assign pulse_output_pin_out = pin_reg;
   assign timer_interrupt_out = irq_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   pin_inverse_a: assert property (pin_reg == ~timer_flipflop_reg)
      else $error("pin not inverse of flip-flop");
   pin_follow_a: assert property (toggle |=> pin_reg != $past(pin_reg))
      else $error("pin did not follow match");
   count_step_a: assert property (advance & !hit_cycle & !ctl_wr |=>
      count_reg == CNT_W'($past(count_reg) + CNT_W'(1)))
      else $error("counter did not step by one");
   width_toggle_a: assert property (hit_width & !hit_cycle |=>
      timer_flipflop_reg != $past(timer_flipflop_reg) && irq_reg)
      else $error("width match did not toggle and interrupt");
   cycle_clear_a: assert property (hit_cycle & !ctl_wr |=>
      count_reg == '0 && irq_reg)
      else $error("cycle match did not clear counter");
   stop_hold_a: assert property (!running_reg & !ctl_wr |=>
      $stable(count_reg) && $stable(pin_reg))
      else $error("stopped timer changed state");
   oneshot_stop_a: assert property (hit_cycle & repeat_select_bit &
      !ctl_wr |=> !running_reg && start_field == 2'h0 && !advance [*3])
      else $error("one shot did not stop");
   continuous_run_a: assert property (hit_cycle & !repeat_select_bit &
      !ctl_wr |=> running_reg)
      else $error("continuous style stopped");
   trigger_start_a: assert property (!running_reg & start_field[1] &
      trig_edge & !ctl_wr |=> running_reg)
      else $error("trigger edge did not start timer");
   irq_cause_a: assert property (irq_reg |-> $past(toggle))
      else $error("interrupt without match");
   reload_skew_a: assert property (ctl_wr & ~running_reg & !toggle &
      wctl[1:0] == 2'h3 |=> timer_flipflop_reg ==
      ($past(wctl[7]) ^ $past(phase_reg)))
      else $error("flip-flop reload wrong");
endmodule : timer_pulse_generator

// File: verif/pulse_load_model.sv
// Purpose: Load on the pulse pin, measures its low time and period
// Assumes: Pin sampled on the reference clock
// Notes: Lengths are counted in reference clock cycles
module pulse_load_model (
   input wire logic ref_clk_in,
   input wire logic pulse_in,
   output int low_len_out,
   output int period_out,
   output int edges_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic prev = 1'b1;
   int run = 0;
   int since_rise = 0;
   initial begin
      low_len_out = 0;
      period_out = 0;
      edges_out = 0;
   end
   // pin level seen by the load
   always @(posedge ref_clk_in) begin
      prev <= pulse_in;
      run <= run + 1;
      since_rise <= since_rise + 1;
      if (pulse_in !== prev) begin
         edges_out <= edges_out + 1;
         run <= 1;
      end
      if (pulse_in === 1'b1 && prev === 1'b0) begin
         low_len_out <= run;
         period_out <= since_rise;
         since_rise <= 1;
      end
   end
endmodule : pulse_load_model

// File: verif/tb.sv
// Purpose: Self-checking bench for the timer pulse generator
// Assumes: Source select 3 ticks every reference cycle
// Notes: Random compare values come from an LFSR seeded with 57
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Design and load
   // ----------------------------------------------------------------
   logic ref_clk_in, rst_n_in, rd, wr, trig, wait_rq, pin, irq;
   logic [3:0] addr, be;
   logic [31:0] wdata, rdata, rv;
   logic [15:0] lfsr, c, w;
   int low_len, period, edges, fails, checks, e0, i0;
   int irqs = 0;
   timer_pulse_generator u_dut (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_rq), .timer_input_pin_in(trig),
      .pulse_output_pin_out(pin), .timer_interrupt_out(irq));
   pulse_load_model u_load (.ref_clk_in(ref_clk_in), .pulse_in(pin),
      .low_len_out(low_len), .period_out(period), .edges_out(edges));
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) if (irq === 1'b1) irqs <= irqs + 1;
   // ----------------------------------------------------------------
   // Bus, expectations and checks
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   function automatic int div_of(input logic [1:0] sel);
      case (sel)
         2'h0: return 1 << timer_pulse_pkg::DIV_LOG_SEL0;
         2'h1: return 1 << timer_pulse_pkg::DIV_LOG_SEL1;
         2'h2: return 1 << timer_pulse_pkg::DIV_LOG_SEL2;
         default: return 1 << timer_pulse_pkg::DIV_LOG_SEL3;
      endcase
   endfunction : div_of
   function automatic logic [31:0] mk_ctrl(input logic ff, rep,
      input logic [1:0] st, sel);
      return {24'h000000, ff, rep, st, sel, timer_pulse_pkg::MODE_PULSE};
   endfunction : mk_ctrl
   task automatic give_verdict;
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w_en, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= w_en;
      rd <= ~w_en;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (wait_rq !== 1'b0 && n < 100);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wait_rq !== 1'b0) begin
         fails++;
         give_verdict();
      end
   endtask : bus
   task automatic ctl(input logic [31:0] d);
      bus(1'b1, timer_pulse_pkg::CTRL_OFS, d, 4'hF);
   endtask : ctl
   task automatic wait_edges(input int n);
      int k;
      k = 0;
      while (edges < n && k < 40000) begin
         @(posedge ref_clk_in);
         k++;
      end
      if (edges < n) begin
         fails++;
         give_verdict();
      end
   endtask : wait_edges
   task automatic reinit(input logic ff);
      ctl(32'h0000000C);
      ctl(mk_ctrl(ff, 1'b0, timer_pulse_pkg::START_STOP, 2'h3));
      repeat (3) @(posedge ref_clk_in);
      chk({31'h00000000, pin}, {31'h00000000, ~ff});
   endtask : reinit
   task automatic setup_run(input logic [15:0] cy, wd);
      reinit(1'b0);
      bus(1'b1, timer_pulse_pkg::CYCLE_OFS, {16'h0000, cy}, 4'h3);
      bus(1'b1, timer_pulse_pkg::WIDTH_OFS, {16'h0000, wd}, 4'h3);
      e0 = edges;
      i0 = irqs;
   endtask : setup_run
   task automatic run_cont(input logic [15:0] cy, wd,
      input logic [1:0] sel);
      int ev;
      setup_run(cy, wd);
      ctl(mk_ctrl(1'b0, 1'b0, timer_pulse_pkg::START_CMD, sel));
      wait_edges(e0 + 4);
      chk(period, (cy + 1) * div_of(sel));
      chk(low_len, (cy - wd) * div_of(sel));
      ctl(mk_ctrl(1'b0, 1'b0, timer_pulse_pkg::START_STOP, sel));
      repeat (3) @(posedge ref_clk_in);
      ev = edges;
      repeat (3 * div_of(sel) + 10) @(posedge ref_clk_in);
      chk(edges, ev);
      chk(irqs - i0, edges - e0);
      bus(1'b0, timer_pulse_pkg::STATUS_OFS, 32'h00000000, 4'hF);
      chk(rv & 32'h0001FFFF, 32'h00000000);
   endtask : run_cont
   task automatic draw;
      lfsr = lfsr_next(lfsr);
      c = 16'(3 + lfsr[3:0]);
      lfsr = lfsr_next(lfsr);
      w = 16'(1 + int'(lfsr) % int'(c - 16'h0001));
   endtask : draw
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h00000000;
      be = 4'hF;
      trig = 1'b0;
      lfsr = 16'h0039;
      fails = 0;
      checks = 0;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      chk({30'h00000000, pin, irq}, 32'h00000002);
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, 4'(k * 4), 32'h00000000, 4'hF);
         chk(rv, 32'h00000000);
      end
      bus(1'b1, timer_pulse_pkg::CYCLE_OFS, 32'hABCD1234, 4'hF);
      bus(1'b1, timer_pulse_pkg::CYCLE_OFS, 32'h00005678, 4'h1);
      bus(1'b0, timer_pulse_pkg::CYCLE_OFS, 32'h00000000, 4'hF);
      chk(rv, 32'h00001278);
      bus(1'b1, timer_pulse_pkg::STATUS_OFS, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, timer_pulse_pkg::STATUS_OFS, 32'h00000000, 4'hF);
      chk(rv, 32'h00000000);
      bus(1'b0, 4'h1, 32'h00000000, 4'hF);
      chk(rv, 32'h00000000);
      run_cont(16'h0002, 16'h0001, 2'h3);
      for (int s = 0; s < 4; s++) begin
         draw();
         run_cont(c, w, 2'(s));
      end
      draw();
      setup_run(c, w);
      ctl(mk_ctrl(1'b0, 1'b1, timer_pulse_pkg::START_CMD, 2'h3));
      wait_edges(e0 + 2);
      repeat (40) @(posedge ref_clk_in);
      chk(edges - e0, 2);
      chk(irqs - i0, 2);
      chk(low_len, c - w);
      chk({31'h00000000, pin}, 32'h00000001);
      bus(1'b0, timer_pulse_pkg::CTRL_OFS, 32'h00000000, 4'hF);
      chk(rv & 32'h00000030, 32'h00000000);
      setup_run(16'h0028, 16'h000A);
      ctl(mk_ctrl(1'b0, 1'b0, timer_pulse_pkg::START_CMD, 2'h3));
      wait_edges(e0 + 1);
      ctl(mk_ctrl(1'b0, 1'b0, timer_pulse_pkg::START_STOP, 2'h3));
      ctl(mk_ctrl(1'b0, 1'b0, timer_pulse_pkg::START_STOP, 2'h3));
      repeat (3) @(posedge ref_clk_in);
      chk({31'h00000000, pin}, 32'h00000000);
      bus(1'b0, timer_pulse_pkg::STATUS_OFS, 32'h00000000, 4'hF);
      chk(rv & 32'h00020000, 32'h00020000);
      reinit(1'b1);
      for (int k = 0; k < 2; k++) begin
         setup_run(16'h0014, 16'h0005);
         ctl(mk_ctrl(1'b0, 1'b0, k == 0 ? timer_pulse_pkg::START_RISE :
            timer_pulse_pkg::START_FALL, 2'h3));
         repeat (20) @(posedge ref_clk_in);
         chk(edges, e0);
         trig <= ~trig;
         wait_edges(e0 + 1);
         chk({31'h00000000, pin}, 32'h00000000);
      end
      give_verdict();
   end
endmodule : tb
